/* File: core/mis_code_mem.sv */
`timescale 1ns/1ps
module mis_code_mem
	import mis_pkg::*;
#(
	parameter int DEPTH = INT_MEM_BYTES,
	parameter int AW = INT_ADDR_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// load port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	// read port, one clock latency
	input wire logic [AW-1:0] rd_addr,
	output logic [7:0] rd_data
);
	logic [7:0] mem [DEPTH];
	logic [7:0] rd_data_reg;

	// array write, no reset on storage
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// registered read data
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data_reg <= 8'h00;
		end else begin
			rd_data_reg <= mem[rd_addr];
		end
	end

	assign rd_data = rd_data_reg;
endmodule

/* File: core/mis_decode.sv */
`timescale 1ns/1ps
module mis_decode
	import mis_pkg::*;
(
	// instruction class
	input wire logic [4:0] cls,
	// length and duration
	output mis_shape_s shape
);
	// byte count and machine cycles per class
	always_comb begin
		unique case (cls)
			CL_NOP, CL_ALU_REG, CL_LOW_NIBBLE_XCHG:
				shape = '{bytes: 2'h1, cycles: 3'h1};
			CL_ALU_DIR:
				shape = '{bytes: 2'h2, cycles: 3'h1};
			CL_LOGIC_DIR_IMM, CL_MOVE_DIR_3B, CL_LOAD_POINTER, CL_FAR_CALL,
			CL_FAR_JUMP, CL_BIT_BRANCH, CL_BIT_BRANCH_CLEAR,
			CL_COMPARE_BRANCH, CL_DEC_BRANCH_DIR:
				shape = '{bytes: 2'h3, cycles: 3'h2};
			CL_MULTIPLY, CL_DIVIDE:
				shape = '{bytes: 2'h1, cycles: 3'h4};
			CL_INC_POINTER, CL_CODE_READ_PTR, CL_CODE_READ_PC, CL_XREAD_REG,
			CL_XREAD_PTR, CL_XWRITE_REG, CL_XWRITE_PTR, CL_RETURN,
			CL_INT_RETURN:
				shape = '{bytes: 2'h1, cycles: 3'h2};
			CL_MOVE_DIR_2B, CL_PUSH, CL_POP, CL_BIT_CARRY, CL_SHORT_CALL,
			CL_SHORT_JUMP, CL_REL_BRANCH, CL_DEC_BRANCH_REG:
				shape = '{bytes: 2'h2, cycles: 3'h2};
		endcase
	end
endmodule

/* File: core/mis_pkg.sv */
package mis_pkg;
	// clock and machine cycle timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int REF_OSC_MHZ = 12;
	localparam int REF_MCYCLE_NS = 1000;
	localparam int OSC_PER_MCYCLE = REF_MCYCLE_NS * REF_OSC_MHZ / 1000;
	localparam int MCYCLE_NS = OSC_PER_MCYCLE * CLK_PERIOD_NS;
	localparam logic [3:0] PHASE_LAST = 4'(OSC_PER_MCYCLE - 1);
	localparam logic [3:0] PHASE_HALF = 4'(OSC_PER_MCYCLE / 2);
	localparam logic [3:0] CAPTURE_LAG = 4'h2;
	localparam logic [3:0] XSTROBE_FIRST = 4'h1;
	localparam logic [3:0] XSTROBE_LAST = 4'h9;
	localparam logic [3:0] XSAMPLE_PHASE = 4'hA;
	// memory map
	localparam logic [15:0] RESET_PC = 16'h0000;
	localparam int INT_MEM_BYTES = 8192;
	localparam int INT_ADDR_W = 13;
	localparam int EXT_CODE_KBYTES = 64;
	// instruction classes (opcode bits 4:0)
	localparam logic [4:0] CL_NOP = 5'h00;
	localparam logic [4:0] CL_ALU_REG = 5'h01;
	localparam logic [4:0] CL_ALU_DIR = 5'h02;
	localparam logic [4:0] CL_LOGIC_DIR_IMM = 5'h03;
	localparam logic [4:0] CL_MULTIPLY = 5'h04;
	localparam logic [4:0] CL_DIVIDE = 5'h05;
	localparam logic [4:0] CL_INC_POINTER = 5'h06;
	localparam logic [4:0] CL_MOVE_DIR_2B = 5'h07;
	localparam logic [4:0] CL_MOVE_DIR_3B = 5'h08;
	localparam logic [4:0] CL_LOAD_POINTER = 5'h09;
	localparam logic [4:0] CL_CODE_READ_PTR = 5'h0A;
	localparam logic [4:0] CL_CODE_READ_PC = 5'h0B;
	localparam logic [4:0] CL_XREAD_REG = 5'h0C;
	localparam logic [4:0] CL_XREAD_PTR = 5'h0D;
	localparam logic [4:0] CL_XWRITE_REG = 5'h0E;
	localparam logic [4:0] CL_XWRITE_PTR = 5'h0F;
	localparam logic [4:0] CL_PUSH = 5'h10;
	localparam logic [4:0] CL_POP = 5'h11;
	localparam logic [4:0] CL_LOW_NIBBLE_XCHG = 5'h12;
	localparam logic [4:0] CL_BIT_CARRY = 5'h13;
	localparam logic [4:0] CL_SHORT_CALL = 5'h14;
	localparam logic [4:0] CL_SHORT_JUMP = 5'h15;
	localparam logic [4:0] CL_FAR_CALL = 5'h16;
	localparam logic [4:0] CL_FAR_JUMP = 5'h17;
	localparam logic [4:0] CL_RETURN = 5'h18;
	localparam logic [4:0] CL_INT_RETURN = 5'h19;
	localparam logic [4:0] CL_REL_BRANCH = 5'h1A;
	localparam logic [4:0] CL_BIT_BRANCH = 5'h1B;
	localparam logic [4:0] CL_BIT_BRANCH_CLEAR = 5'h1C;
	localparam logic [4:0] CL_COMPARE_BRANCH = 5'h1D;
	localparam logic [4:0] CL_DEC_BRANCH_REG = 5'h1E;
	localparam logic [4:0] CL_DEC_BRANCH_DIR = 5'h1F;
	localparam logic [2:0] SUB_JUMP_INDIRECT = 3'h1;
	// port 3 bit positions
	localparam int P3_IRQ0_BIT = 2;
	localparam int P3_IRQ1_BIT = 3;
	localparam int P3_CNT0_BIT = 4;
	localparam int P3_CNT1_BIT = 5;
	localparam int P3_WR_BIT = 6;
	localparam int P3_RD_BIT = 7;

	typedef enum logic [1:0] {ST_START, ST_RUN, ST_POWER_DOWN} mis_state_e;

	typedef struct packed {
		logic [1:0] bytes;
		logic [2:0] cycles;
	} mis_shape_s;

	typedef struct packed {
		logic valid;
		logic [4:0] cls;
		logic [2:0] sub;
		logic [7:0] op1;
		logic [7:0] op2;
	} mis_exec_s;

	// base plus unsigned byte offset
	function automatic logic [15:0] mis_add_offset(logic [15:0] base,
		logic [7:0] off);
		return base + {8'h00, off};
	endfunction

	// base plus signed byte displacement
	function automatic logic [15:0] mis_rel_target(logic [15:0] base,
		logic [7:0] rel);
		return base + {{8{rel[7]}}, rel};
	endfunction
endpackage

/* File: core/mis_sequencer.sv */
`timescale 1ns/1ps
// Summary of operation
// - multiply and divide are one byte and take four machine cycles.
// - data pointer increment is one byte, two machine cycles.
// - add, add-with-carry, subtract: one cycle; register forms 1 byte, else 2.
// - logic immediate into direct byte: three bytes, two cycles; others one.
// - accumulator clear, complement, rotates, nibble swap: one byte, one cycle.
// - direct-byte moves with non-accumulator partner take two cycles.
// - sixteen-bit pointer load is three bytes in two cycles.
// - code byte read at accumulator plus pointer or pc: one byte, two cycles.
// - external data moves use 8 or 16 bit address; one byte, two cycles.
// - push and pop of a direct byte: two bytes, two cycles.
// - low nibble exchange is one byte, one cycle; high nibbles kept.
// - carry/bit set-clear-complement one cycle; bit logic into carry two.
// - calls, returns, jumps, branches take two cycles; no-op takes one.
// - bit branch-and-clear is three bytes; clears the bit when taken.
// - compare-and-branch-unequal forms are three bytes.
// - short page transfers carry 11 bits in 2 bytes; far ones 16 in 3.
// - rising edge on the reset pin with main supply ok restarts fetching at address zero.
// - source select high runs internal 8K memory, low runs external 64K.
// - main supply loss with standby high enters power-down.
// - a port 3 alternate function works only while its latch bit is one.
// - port 3 bit 6 is the write strobe, bit 7 the read strobe, low.
// - port 3 bits 2 and 3 are interrupts or gates for bits 4 and 5.
// - a machine cycle is twelve oscillator periods.
module mis_sequencer
	import mis_pkg::*;
#(
	parameter int INT_MEM_DEPTH = INT_MEM_BYTES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// supply and strap pins
	input wire logic reset_standby_pin,
	input wire logic standby_supply,
	input wire logic main_supply_ok,
	input wire logic program_source_select,
	// external program memory
	output logic [15:0] code_addr,
	output logic code_fetch_strobe_n,
	input wire logic [7:0] code_rdata,
	// internal program memory load
	input wire logic mem_load_en,
	input wire logic [INT_ADDR_W-1:0] mem_load_addr,
	input wire logic [7:0] mem_load_data,
	// datapath side
	input wire logic [7:0] acc_value,
	input wire logic [7:0] indirect_addr,
	input wire logic [15:0] return_addr,
	input wire logic branch_cond,
	output mis_exec_s exec,
	output logic bit_clear,
	output logic [7:0] code_byte,
	output logic [15:0] data_pointer,
	output logic [15:0] program_counter,
	// external data memory
	output logic [15:0] xdata_addr,
	output logic [7:0] xdata_wdata,
	input wire logic [7:0] xdata_rdata,
	output logic [7:0] xdata_rbyte,
	// port 3
	input wire logic [7:0] p3_latch,
	input wire logic [7:0] p3_pin_in,
	input wire logic [1:0] counter_gate_mode,
	output logic [7:0] p3_pin_out,
	output logic [7:0] p3_pin_oe_n,
	output logic ext_irq_zero,
	output logic ext_irq_one,
	output logic counter_input_zero,
	output logic counter_input_one,
	// power state
	output logic power_down
);
	mis_state_e state_reg;
	logic [3:0] phase_reg;
	logic [1:0] mcyc_reg;
	logic [7:0] opcode_reg, op1_reg, op2_reg, code_byte_reg, xdata_rbyte_reg;
	logic [15:0] pc_reg, dp_reg, code_addr_reg, xdata_addr_reg;
	logic [7:0] xdata_wdata_reg, p3_out_reg;
	logic src_internal_reg, fetch_int_reg, fetch_pend_reg, strobe_n_reg;
	logic rst_pin_q_reg, rd_n_reg, wr_n_reg, bit_clear_reg, power_down_reg;
	logic irq0_reg, irq1_reg, cnt0_reg, cnt1_reg;
	mis_exec_s exec_reg;
	mis_shape_s shape;
	logic [7:0] mem_rdata;

	// class decode of the current opcode
	wire [4:0] cls = opcode_reg[4:0];
	wire [2:0] sub = opcode_reg[7:5];
	mis_decode u_decode (
		.cls(cls),
		.shape(shape)
	);

	// internal program memory
	mis_code_mem #(
		.DEPTH(INT_MEM_DEPTH),
		.AW(INT_ADDR_W)
	) u_code_mem (
		.clk(clk),
		.reset_n(reset_n),
		.wr_en(mem_load_en),
		.wr_addr(mem_load_addr),
		.wr_data(mem_load_data),
		.rd_addr(code_addr_reg[INT_ADDR_W-1:0]),
		.rd_data(mem_rdata)
	);

	// timing within a machine cycle
	wire running = state_reg == ST_RUN;
	wire rst_rise = reset_standby_pin & ~rst_pin_q_reg & main_supply_ok;
	wire pd_enter = running & standby_supply & ~main_supply_ok;
	wire half = phase_reg >= PHASE_HALF;
	wire [2:0] slot_num = {mcyc_reg, half};
	wire at_slot = running & (phase_reg == 4'h0 || phase_reg == PHASE_HALF);
	wire at_capture = running & fetch_pend_reg &
		(phase_reg == CAPTURE_LAG || phase_reg == PHASE_HALF + CAPTURE_LAG);
	wire finish = running & phase_reg == PHASE_LAST &
		{1'b0, mcyc_reg} == shape.cycles - 3'h1;

	// instruction groups that steer the sequence
	wire is_code_read = cls == CL_CODE_READ_PTR || cls == CL_CODE_READ_PC;
	wire is_xread = cls == CL_XREAD_REG || cls == CL_XREAD_PTR;
	wire is_xwrite = cls == CL_XWRITE_REG || cls == CL_XWRITE_PTR;
	wire is_xptr = cls == CL_XREAD_PTR || cls == CL_XWRITE_PTR;
	wire is_page = cls == CL_SHORT_CALL || cls == CL_SHORT_JUMP;
	wire is_far = cls == CL_FAR_CALL || cls == CL_FAR_JUMP;
	wire is_jind = cls == CL_RETURN && sub == SUB_JUMP_INDIRECT;
	wire is_ret = (cls == CL_RETURN && !is_jind) || cls == CL_INT_RETURN;
	wire rel_op1 = cls == CL_REL_BRANCH || cls == CL_DEC_BRANCH_REG;
	wire rel_op2 = cls == CL_BIT_BRANCH || cls == CL_BIT_BRANCH_CLEAR ||
		cls == CL_COMPARE_BRANCH || cls == CL_DEC_BRANCH_DIR;

	// fetch selection and address
	wire fetch_pc = at_slot &
		(slot_num == 3'h0 || slot_num < {1'b0, shape.bytes});
	wire fetch_cr = at_slot & slot_num == 3'h3 & is_code_read;
	wire [15:0] cr_addr = (cls == CL_CODE_READ_PTR) ?
		mis_add_offset(dp_reg, acc_value) : mis_add_offset(pc_reg, acc_value);
	wire [15:0] fetch_addr = fetch_cr ? cr_addr : pc_reg;
	wire fetch_int = src_internal_reg & fetch_addr[15:13] == 3'h0;
	wire [7:0] fetched = fetch_int_reg ? mem_rdata : code_rdata;

	// program counter after a control transfer
	wire [15:0] pc_target =
		is_page ? {pc_reg[15:11], sub, op1_reg} :
		is_far ? {op1_reg, op2_reg} :
		is_ret ? return_addr :
		is_jind ? mis_add_offset(dp_reg, acc_value) :
		(rel_op1 & branch_cond) ? mis_rel_target(pc_reg, op1_reg) :
		(rel_op2 & branch_cond) ? mis_rel_target(pc_reg, op2_reg) : pc_reg;

	// external data strobe window in the second cycle
	wire xwin = mcyc_reg == 2'h1 & phase_reg >= XSTROBE_FIRST &
		phase_reg <= XSTROBE_LAST;

	// run state, supply loss and reset pin edge
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_START;
			rst_pin_q_reg <= 1'b0;
			src_internal_reg <= 1'b1;
			power_down_reg <= 1'b0;
		end else begin
			rst_pin_q_reg <= reset_standby_pin;
			if (rst_rise || state_reg == ST_START) begin
				state_reg <= ST_RUN;
				src_internal_reg <= program_source_select;
				power_down_reg <= 1'b0;
			end else if (pd_enter) begin
				state_reg <= ST_POWER_DOWN;
				power_down_reg <= 1'b1;
			end
		end
	end

	// phase and machine cycle counters
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_reg <= 4'h0;
			mcyc_reg <= 2'h0;
		end else if (rst_rise || !running) begin
			phase_reg <= 4'h0;
			mcyc_reg <= 2'h0;
		end else if (phase_reg == PHASE_LAST) begin
			phase_reg <= 4'h0;
			mcyc_reg <= finish ? 2'h0 : mcyc_reg + 2'h1;
		end else begin
			phase_reg <= phase_reg + 4'h1;
		end
	end

	// code bus: address, strobe and byte capture
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			code_addr_reg <= RESET_PC;
			strobe_n_reg <= 1'b1;
			fetch_int_reg <= 1'b1;
			fetch_pend_reg <= 1'b0;
			opcode_reg <= 8'h00;
			op1_reg <= 8'h00;
			op2_reg <= 8'h00;
			code_byte_reg <= 8'h00;
		end else if (fetch_pc || fetch_cr) begin
			code_addr_reg <= fetch_addr;
			strobe_n_reg <= fetch_int;
			fetch_int_reg <= fetch_int;
			fetch_pend_reg <= 1'b1;
		end else if (!running) begin
			// power-down must not leave a fetch strobe hanging low
			strobe_n_reg <= 1'b1;
			fetch_pend_reg <= 1'b0;
		end else if (at_capture) begin
			strobe_n_reg <= 1'b1;
			fetch_pend_reg <= 1'b0;
			unique case (slot_num)
				3'h0: opcode_reg <= fetched;
				3'h1: op1_reg <= fetched;
				3'h2: op2_reg <= fetched;
				default: code_byte_reg <= fetched;
			endcase
		end
	end

	// program counter and data pointer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pc_reg <= RESET_PC;
			dp_reg <= 16'h0000;
		end else if (rst_rise) begin
			pc_reg <= RESET_PC;
		end else if (fetch_pc) begin
			pc_reg <= pc_reg + 16'h0001;
		end else if (finish) begin
			pc_reg <= pc_target;
			if (cls == CL_LOAD_POINTER) begin
				dp_reg <= {op1_reg, op2_reg};
			end else if (cls == CL_INC_POINTER) begin
				dp_reg <= dp_reg + 16'h0001;
			end
		end
	end

	// execute hand-off to the datapath
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			exec_reg <= '0;
			bit_clear_reg <= 1'b0;
		end else begin
			exec_reg <= '{valid: finish, cls: cls, sub: sub, op1: op1_reg,
				op2: op2_reg};
			bit_clear_reg <= finish & cls == CL_BIT_BRANCH_CLEAR &
				branch_cond;
		end
	end

	// external data address, strobes and read byte
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			xdata_addr_reg <= 16'h0000;
			xdata_wdata_reg <= 8'h00;
			xdata_rbyte_reg <= 8'h00;
			rd_n_reg <= 1'b1;
			wr_n_reg <= 1'b1;
		end else begin
			if (running && mcyc_reg == 2'h1 && phase_reg == 4'h0 &&
				(is_xread || is_xwrite)) begin
				xdata_addr_reg <= is_xptr ? dp_reg :
					{8'h00, indirect_addr};
				xdata_wdata_reg <= acc_value;
			end
			rd_n_reg <= ~(running & xwin & is_xread);
			wr_n_reg <= ~(running & xwin & is_xwrite);
			if (!rd_n_reg && phase_reg == XSAMPLE_PHASE) begin
				xdata_rbyte_reg <= xdata_rdata;
			end
		end
	end

	// port 3 alternate functions, each gated by its latch bit
	wire [7:0] p3_alt = {rd_n_reg, wr_n_reg, 6'h3F};
	wire gate0 = p3_latch[P3_IRQ0_BIT] & p3_pin_in[P3_IRQ0_BIT];
	wire gate1 = p3_latch[P3_IRQ1_BIT] & p3_pin_in[P3_IRQ1_BIT];
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			p3_out_reg <= 8'hFF;
			irq0_reg <= 1'b0;
			irq1_reg <= 1'b0;
			cnt0_reg <= 1'b0;
			cnt1_reg <= 1'b0;
		end else begin
			p3_out_reg <= p3_latch & p3_alt;
			irq0_reg <= p3_latch[P3_IRQ0_BIT] & ~counter_gate_mode[0] &
				~p3_pin_in[P3_IRQ0_BIT];
			irq1_reg <= p3_latch[P3_IRQ1_BIT] & ~counter_gate_mode[1] &
				~p3_pin_in[P3_IRQ1_BIT];
			cnt0_reg <= p3_latch[P3_CNT0_BIT] & p3_pin_in[P3_CNT0_BIT] &
				(~counter_gate_mode[0] | gate0);
			cnt1_reg <= p3_latch[P3_CNT1_BIT] & p3_pin_in[P3_CNT1_BIT] &
				(~counter_gate_mode[1] | gate1);
		end
	end

	// outputs straight from flops
	assign code_addr = code_addr_reg;
	assign code_fetch_strobe_n = strobe_n_reg;
	assign exec = exec_reg;
	assign bit_clear = bit_clear_reg;
	assign code_byte = code_byte_reg;
	assign data_pointer = dp_reg;
	assign program_counter = pc_reg;
	assign xdata_addr = xdata_addr_reg;
	assign xdata_wdata = xdata_wdata_reg;
	assign xdata_rbyte = xdata_rbyte_reg;
	assign p3_pin_out = p3_out_reg;
	assign p3_pin_oe_n = p3_out_reg;
	assign ext_irq_zero = irq0_reg;
	assign ext_irq_one = irq1_reg;
	assign counter_input_zero = cnt0_reg;
	assign counter_input_one = cnt1_reg;
	assign power_down = power_down_reg;

	// checker helpers: clocks and bytes per instruction
	logic [5:0] len_cnt_reg;
	logic [1:0] bytes_seen_reg;
	logic [15:0] start_pc_reg;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			len_cnt_reg <= 6'h00;
			bytes_seen_reg <= 2'h0;
			start_pc_reg <= 16'h0000;
		end else begin
			len_cnt_reg <= (finish || !running || rst_rise) ? 6'h00 :
				len_cnt_reg + 6'h01;
			bytes_seen_reg <= (finish || !running || rst_rise) ? 2'h0 :
				bytes_seen_reg + {1'b0, fetch_pc};
			if (fetch_pc && slot_num == 3'h0) begin
				start_pc_reg <= pc_reg;
			end
		end
	end
	wire plain = !(is_page || is_far || is_ret || is_jind || rel_op1 ||
		rel_op2);

	a_muldiv_four_cycles: assert property (@(posedge clk) disable iff (!reset_n)
		finish && (cls == CL_MULTIPLY || cls == CL_DIVIDE) |->
		len_cnt_reg == 6'h2F && bytes_seen_reg == 2'h1)
		else $error("multiply or divide not four cycles");
	a_pointer_inc_step: assert property (@(posedge clk) disable iff (!reset_n)
		finish && cls == CL_INC_POINTER && len_cnt_reg == 6'h17 |=>
		dp_reg == $past(dp_reg) + 16'h0001)
		else $error("pointer increment wrong");
	a_alu_one_cycle: assert property (@(posedge clk) disable iff (!reset_n)
		finish && cls == CL_ALU_REG |-> len_cnt_reg == 6'h0B)
		else $error("single cycle op too long");
	a_logic_three_bytes: assert property (@(posedge clk) disable iff (!reset_n)
		finish && cls == CL_LOGIC_DIR_IMM |->
		bytes_seen_reg == 2'h3 && len_cnt_reg == 6'h17)
		else $error("logic immediate to direct shape wrong");
	a_pointer_load: assert property (@(posedge clk) disable iff (!reset_n)
		finish && cls == CL_LOAD_POINTER |=>
		dp_reg == {$past(op1_reg), $past(op2_reg)})
		else $error("pointer load value wrong");
	a_xread_strobe: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(rd_n_reg) |=> !rd_n_reg [*8] ##1 rd_n_reg)
		else $error("read strobe width wrong");
	a_bit_clear_taken: assert property (@(posedge clk) disable iff (!reset_n)
		finish && cls == CL_BIT_BRANCH_CLEAR && branch_cond |=>
		bit_clear_reg && pc_reg == mis_rel_target($past(pc_reg),
		$past(op2_reg)))
		else $error("bit branch clear missed");
	a_far_target: assert property (@(posedge clk) disable iff (!reset_n)
		finish && is_far |-> bytes_seen_reg == 2'h3 ##1
		pc_reg == {$past(op1_reg), $past(op2_reg)})
		else $error("far transfer target wrong");
	a_reset_to_zero: assert property (@(posedge clk) disable iff (!reset_n)
		rst_rise |=> pc_reg == RESET_PC ##1 code_addr_reg == RESET_PC)
		else $error("reset edge did not restart at zero");
	a_pc_advance: assert property (@(posedge clk) disable iff (!reset_n)
		finish && plain |-> pc_reg == start_pc_reg + {14'h0000, shape.bytes})
		else $error("pc did not pass operand bytes");
	a_power_down: assert property (@(posedge clk) disable iff (!reset_n)
		pd_enter && !rst_rise |=> power_down_reg && !running)
		else $error("power-down not entered");
	a_latch_gates_wr: assert property (@(posedge clk) disable iff (!reset_n)
		!p3_latch[P3_WR_BIT] |=> !p3_out_reg[P3_WR_BIT])
		else $error("alternate function active with latch low");
endmodule

/* File: testbench/mis_ext_mem.sv */
`timescale 1ns/1ps
module mis_ext_mem (
	// clock
	input wire logic clk,
	// program memory side
	input wire logic [15:0] code_addr,
	input wire logic code_fetch_strobe_n,
	output logic [7:0] code_rdata,
	// data memory side
	input wire logic [15:0] xdata_addr,
	input wire logic [7:0] p3_pin_out,
	output logic [7:0] xdata_rdata
);
	logic [7:0] code_mem [0:65535];
	logic [7:0] junk_reg = 8'h00;
	// released bus shows a value negated every clock, which starts at zero and stays zero
	always @(posedge clk) begin
		junk_reg <= ~junk_reg + 8'h01;
	end
	// drive code only while the fetch strobe is low
	assign code_rdata = code_fetch_strobe_n ? junk_reg
		: code_mem[code_addr];
	// drive data only while the read strobe pin is low
	assign xdata_rdata = p3_pin_out[7] ? junk_reg
		: xdata_addr[7:0] ^ xdata_addr[15:8];
endmodule

/* File: testbench/test_mis_sequencer.sv */
`timescale 1ns/1ps
module test_mis_sequencer;
	import mis_pkg::*;
	localparam int NI = 100;
	localparam logic [4:0] CORNER [4] = '{CL_MULTIPLY, CL_BIT_BRANCH_CLEAR,
		CL_XREAD_PTR, CL_XWRITE_REG};
	typedef struct {
		logic [7:0] op;
		logic [7:0] b2;
		logic [15:0] pc;
		logic [15:0] ret;
		logic cond;
		logic [7:0] lat;
	} mis_rec_s;
	logic clk = 1'b0;
	logic reset_n = 1'b0, reset_standby_pin = 1'b0, standby_supply = 1'b0;
	logic main_supply_ok = 1'b1, program_source_select = 1'b0;
	logic mem_load_en = 1'b0, branch_cond = 1'b0, bit_clear, power_down;
	logic [INT_ADDR_W-1:0] mem_load_addr = '0;
	logic [7:0] mem_load_data = 8'h00, acc_value = 8'h00;
	logic [7:0] indirect_addr = 8'h00, p3_latch = 8'hFF, p3_ext = 8'hFF;
	logic [7:0] p3_pin_out, p3_pin_oe_n, code_rdata, code_byte, xdata_wdata;
	logic [7:0] xdata_rdata, xdata_rbyte;
	logic [15:0] return_addr = 16'h0000, code_addr, data_pointer, top;
	logic [15:0] program_counter, xdata_addr;
	logic [1:0] counter_gate_mode = 2'h0;
	logic code_fetch_strobe_n, ext_irq_zero, ext_irq_one;
	logic counter_input_zero, counter_input_one, phase2 = 1'b0;
	mis_exec_s exec;
	int error_cnt = 0, n_tests = 0, ext_cnt = 0;
	mis_rec_s prog [NI];
	// open-drain port 3 wire: pull-up, design and outside pull low
	wire [7:0] p3_pin_in = (p3_pin_oe_n | p3_pin_out) & p3_ext;

	mis_sequencer u_mis_sequencer (
		.clk, .reset_n, .reset_standby_pin, .standby_supply, .main_supply_ok,
		.program_source_select, .code_addr, .code_fetch_strobe_n, .code_rdata,
		.mem_load_en, .mem_load_addr, .mem_load_data, .acc_value,
		.indirect_addr, .return_addr, .branch_cond, .exec, .bit_clear,
		.code_byte, .data_pointer, .program_counter, .xdata_addr,
		.xdata_wdata, .xdata_rdata, .xdata_rbyte, .p3_latch, .p3_pin_in,
		.counter_gate_mode, .p3_pin_out, .p3_pin_oe_n, .ext_irq_zero,
		.ext_irq_one, .counter_input_zero, .counter_input_one, .power_down
	);
	mis_ext_mem u_mis_ext_mem (.clk, .code_addr, .code_fetch_strobe_n,
		.code_rdata, .xdata_addr, .p3_pin_out, .xdata_rdata);

	// clock
	initial begin
		forever #(CLK_PERIOD_NS / 2) clk = ~clk;
	end

	task automatic check(logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h",
				$time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d, errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// length and machine cycles of each class except bit-carry, which falls to the default
	function automatic mis_shape_s shape_of(logic [4:0] c);
		case (c)
			CL_NOP, CL_ALU_REG, CL_LOW_NIBBLE_XCHG: return '{2'h1, 3'h1};
			CL_ALU_DIR: return '{2'h2, 3'h1};
			CL_MULTIPLY, CL_DIVIDE: return '{2'h1, 3'h4};
			CL_MOVE_DIR_2B, CL_PUSH, CL_POP, CL_SHORT_CALL, CL_SHORT_JUMP,
			CL_REL_BRANCH, CL_DEC_BRANCH_REG: return '{2'h2, 3'h2};
			CL_LOGIC_DIR_IMM, CL_MOVE_DIR_3B, CL_LOAD_POINTER, CL_FAR_CALL,
			CL_FAR_JUMP, CL_BIT_BRANCH, CL_BIT_BRANCH_CLEAR, CL_COMPARE_BRANCH,
			CL_DEC_BRANCH_DIR: return '{2'h3, 3'h2};
			default: return '{2'h1, 3'h2};
		endcase
	endfunction

	// strobe-low clocks seen on a port 3 pin during one instruction
	function automatic int lows(logic en, logic lat, int gap);
		return !lat ? gap - 2 : (en ? 9 : 0);
	endfunction

	// lay out a random program with zero displacements and fresh targets
	task automatic build();
		logic [15:0] pc, nx;
		logic [7:0] op, b2, b3;
		mis_shape_s sh;
		pc = RESET_PC;
		for (int i = 0; i < NI; i++) begin
			op = 8'($urandom);
			if (i < 4) op[4:0] = CORNER[i];
			if (op[4:0] == CL_BIT_CARRY) op[4:0] = CL_NOP;
			if (op[4:0] == CL_RETURN) op[7:5] = 3'h0;
			sh = shape_of(op[4:0]);
			b2 = 8'($urandom);
			b3 = 8'($urandom);
			nx = pc + 16'(sh.bytes);
			prog[i].ret = nx + 16'($urandom_range(0, 9));
			prog[i].pc = nx;
			case (op[4:0])
				CL_SHORT_CALL, CL_SHORT_JUMP: {op[7:5], b2} = nx[10:0];
				CL_FAR_CALL, CL_FAR_JUMP: begin
					{b2, b3} = prog[i].ret;
					prog[i].pc = prog[i].ret;
				end
				CL_RETURN, CL_INT_RETURN: prog[i].pc = prog[i].ret;
				CL_REL_BRANCH, CL_DEC_BRANCH_REG: b2 = 8'h00;
				CL_LOAD_POINTER: b2[7:4] = 4'h0;
				CL_BIT_BRANCH, CL_BIT_BRANCH_CLEAR, CL_COMPARE_BRANCH,
				CL_DEC_BRANCH_DIR: b3 = 8'h00;
				default: ;
			endcase
			u_mis_ext_mem.code_mem[pc] = op;
			u_mis_ext_mem.code_mem[pc + 16'h0001] = b2;
			u_mis_ext_mem.code_mem[pc + 16'h0002] = b3;
			prog[i].op = op;
			prog[i].b2 = b2;
			prog[i].cond = (i == 1) || 1'($urandom);
			prog[i].lat = {2'($urandom), 6'h3F};
			pc = prog[i].pc;
		end
		// park on a jump to itself
		u_mis_ext_mem.code_mem[pc] = {3'h0, CL_FAR_JUMP};
		u_mis_ext_mem.code_mem[pc + 16'h0001] = pc[15:8];
		u_mis_ext_mem.code_mem[pc + 16'h0002] = pc[7:0];
		top = pc + 16'h0003;
	endtask

	// step through the program, one instruction per end pulse
	task automatic run_prog();
		int gap, rd_lo, wr_lo;
		logic [4:0] c;
		logic [7:0] acc, ind, ext;
		logic [1:0] gm;
		mis_shape_s sh;
		for (int i = 0; i < NI; i++) begin
			c = prog[i].op[4:0];
			sh = shape_of(c);
			@(posedge clk);
			branch_cond <= prog[i].cond;
			return_addr <= prog[i].ret;
			p3_latch <= prog[i].lat;
			acc = 8'($urandom);
			ind = 8'($urandom);
			ext = 8'($urandom) | 8'hC0;
			gm = 2'($urandom);
			acc_value <= acc;
			indirect_addr <= ind;
			p3_ext <= ext;
			counter_gate_mode <= gm;
			gap = 0;
			rd_lo = 0;
			wr_lo = 0;
			do begin
				@(negedge clk);
				gap++;
				if (gap > 2) rd_lo += int'(p3_pin_out[7] === 1'b0);
				if (gap > 2) wr_lo += int'(p3_pin_out[6] === 1'b0);
			end while (exec.valid !== 1'b1 && gap < 60);
			check(32'(exec.valid), 32'h0000_0001);
			check(32'(exec.cls), 32'(c));
			check(32'(program_counter), 32'(prog[i].pc));
			if (i > 0) check(32'(gap), 32'(12 * sh.cycles));
			if (sh.bytes > 2'h1) check(32'(exec.op1), 32'(prog[i].b2));
			check(32'(bit_clear),
				32'(c == CL_BIT_BRANCH_CLEAR && prog[i].cond));
			check(32'(rd_lo), 32'(lows(c == CL_XREAD_REG || c == CL_XREAD_PTR,
				prog[i].lat[7], gap)));
			check(32'(wr_lo), 32'(lows(c == CL_XWRITE_REG
				|| c == CL_XWRITE_PTR, prog[i].lat[6], gap)));
			check(32'(ext_irq_zero), 32'(!gm[0] && !ext[2]));
			check(32'(counter_input_one),
				32'(ext[5] && (!gm[1] || ext[3])));
			if (c == CL_XREAD_REG || c == CL_XWRITE_REG)
				check(32'(xdata_addr), 32'(ind));
			if (c == CL_XREAD_REG) check(32'(xdata_rbyte), 32'(ind));
			if (c == CL_XWRITE_REG || c == CL_XWRITE_PTR)
				check(32'(xdata_wdata), 32'(acc));
			if (c == CL_CODE_READ_PC && prog[i].pc + 16'(acc) < top)
				check(32'(code_byte), 32'(u_mis_ext_mem.code_mem[
					prog[i].pc + 16'(acc)]));
		end
	endtask

	// external fetches while running from internal memory
	always @(negedge clk) begin
		if (phase2 && code_fetch_strobe_n === 1'b0) ext_cnt++;
	end

	// main sequence
	initial begin
		void'($urandom(32'hd404_b6f4));
		build();
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		for (int k = 0; k < 10 && code_fetch_strobe_n !== 1'b0; k++)
			@(negedge clk);
		check(32'(code_addr), 32'(RESET_PC));
		run_prog();
		@(posedge clk);
		standby_supply <= 1'b1;
		main_supply_ok <= 1'b0;
		for (int k = 0; k < 40 && power_down !== 1'b1; k++) @(negedge clk);
		check(32'(power_down), 32'h0000_0001);
		for (int a = 0; a < top; a++) begin
			@(posedge clk);
			mem_load_en <= 1'b1;
			mem_load_addr <= INT_ADDR_W'(a);
			mem_load_data <= u_mis_ext_mem.code_mem[a];
		end
		@(posedge clk);
		mem_load_en <= 1'b0;
		main_supply_ok <= 1'b1;
		program_source_select <= 1'b1;
		phase2 <= 1'b1;
		@(posedge clk);
		reset_standby_pin <= 1'b1;
		repeat (3) @(negedge clk);
		check(32'(code_addr), 32'(RESET_PC));
		check(32'(power_down), 32'h0000_0000);
		run_prog();
		check(32'(ext_cnt), 32'h0000_0000);
		tally_and_finish();
	end

	// watchdog
	initial begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		tally_and_finish();
	end
endmodule
